//--- seng_pkg.sv
// Constants, enums and carrier types for the serial EEPROM command engine
package seng_pkg;

  // Opcodes
  localparam logic [7:0] OP_SET_WEL = 8'h06;
  localparam logic [7:0] OP_CLR_WEL = 8'h04;
  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_WR_STATUS = 8'h01;
  localparam logic [7:0] OP_RD_ARRAY = 8'h03;
  localparam logic [7:0] OP_WR_ARRAY = 8'h02;
  localparam logic [7:0] OP_RD_SECTOR = 8'h83;
  localparam logic [7:0] OP_WR_SECTOR = 8'h82;

  // Geometry
  localparam int ARRAY_DEPTH = 2048;
  localparam int ADDR_W = 11;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_W = 5;
  localparam logic [PAGE_W-1:0] PAGE_LAST = 5'h1f;
  localparam int UID_BYTES = 16;

  // Status register bit positions
  localparam int ST_WIP = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 3;
  localparam int ST_STATUS_LOCK_BIT = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // Block-protect levels and protected bases
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;
  localparam logic [10:0] PROT_QUARTER_BASE = 11'h600;
  localparam logic [10:0] PROT_HALF_BASE = 11'h400;

  // Sector sub-decoding on address bits 10:9
  localparam logic [1:0] SEL_DATA = 2'h0;
  localparam logic [1:0] SEL_LOCK = 2'h2;
  localparam int ADDR_UID_BIT = 9;
  localparam int LOCK_DATA_BIT = 1;
  localparam logic [7:0] LOCK_STATUS_ON = 8'h02;

  // Self-timed write cycle
  localparam int CLK_PERIOD_NS = 8;
  localparam int TW_DEFAULT_US = 5000;
  localparam int TW_DEFAULT_CYCLES = (TW_DEFAULT_US * 1000) / CLK_PERIOD_NS;

  // Arbitrary identifier value
  localparam logic [127:0] UID_DEFAULT = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;

  typedef enum logic [2:0] {TGT_NONE, TGT_STATUS, TGT_ARRAY, TGT_SECTOR, TGT_LOCK} seng_target_e;
  typedef enum logic [1:0] {SQ_IDLE, SQ_PROGRAM, SQ_WAIT} seng_state_e;

  typedef struct packed {
    seng_target_e target;
    logic [ADDR_W-1:0] addr;
    logic [PAGE_BYTES-1:0] mask;
  } seng_job_s;

endpackage : seng_pkg

//--- seng_spi_eeprom.sv
// SPI EEPROM command engine: serial decode on the link clock, write sequencing on MCLK
`timescale 1ns/1ps
module seng_spi_eeprom
  import seng_pkg::*;
#(
  parameter int TW_CYCLES = TW_DEFAULT_CYCLES,
  parameter logic [127:0] UID_VALUE = UID_DEFAULT
) (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic SCK_I,
  input wire logic CS_N_I,
  input wire logic SI_I,
  input wire logic WP_N_I,
  output logic SO_O,
  output logic SO_OE_O,
  output logic [7:0] STATUS_O,
  output logic LOCKED_O
);

  localparam int TW_W = $clog2(TW_CYCLES + 1);
  localparam logic [TW_W-1:0] TW_LAST = TW_W'(TW_CYCLES - 1);

  // ---------------- Link clock domain ----------------
  logic in_frame;
  logic [2:0] bit_cnt;
  logic [1:0] phase;
  logic [6:0] shift;
  logic [7:0] byte_in;
  logic byte_end;
  logic [7:0] opcode;
  logic [15:0] addr;
  logic [7:0] sr_data;
  logic blocked;
  logic [PAGE_W-1:0] ptr;
  logic [PAGE_BYTES-1:0] mask;
  logic [7:0] page_buf [PAGE_BYTES];
  logic [ADDR_W-1:0] rd_addr;
  logic [8:0] stat_s1;
  logic [8:0] stat_s2;
  logic link_wip;
  logic link_lock;
  logic is_write;
  logic out_valid;
  logic [7:0] out_byte;
  logic [7:0] tx;

  // ---------------- MCLK domain ----------------
  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  logic wp_s1;
  logic wp_s2;
  logic frame_end;
  logic cycle_in_progress;
  logic write_enable_latch;
  logic [1:0] bp;
  logic status_lock_bit;
  logic lock;
  logic [7:0] status_q;
  logic aligned_cmd;
  logic aligned_sr;
  logic aligned_data;
  logic accept;
  logic prot_hit;
  logic cycle_done;
  seng_target_e next_target;
  seng_state_e state;
  seng_job_s job;
  logic [PAGE_W-1:0] prog_idx;
  logic [TW_W-1:0] tw_cnt;
  logic [7:0] mem [ARRAY_DEPTH];
  logic [7:0] sector [PAGE_BYTES];

  assign byte_in = {shift, SI_I};
  assign byte_end = in_frame && (bit_cnt == 3'h7);
  assign link_wip = stat_s2[ST_WIP];
  assign link_lock = stat_s2[8];
  assign is_write = (opcode == OP_WR_ARRAY) || (opcode == OP_WR_SECTOR);

  // Cleared while deselected; marks every edge after the first of a frame
  always_ff @(posedge SCK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      in_frame <= 1'b0;
    end else begin
      in_frame <= 1'b1;
    end
  end

  // Bit and byte position; left standing after deselect for the commit side
  always_ff @(posedge SCK_I) begin
    if (!in_frame) begin
      bit_cnt <= 3'h1;
      phase <= 2'h0;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7 && phase != 2'h3) begin
        phase <= phase + 2'h1;
      end
    end
    shift <= byte_in[6:0];
  end

  // Status crosses in as a level pair
  always_ff @(posedge SCK_I) begin
    stat_s1 <= {lock, status_q};
    stat_s2 <= stat_s1;
  end

  // Opcode, address and read pointer capture
  always_ff @(posedge SCK_I) begin
    if (byte_end) begin
      unique case (phase)
        2'h0: begin
          opcode <= byte_in;
          blocked <= link_wip;
        end
        2'h1: begin
          addr[15:8] <= byte_in;
          sr_data <= byte_in;
        end
        2'h2: begin
          addr[7:0] <= byte_in;
          rd_addr <= {addr[10:8], byte_in};
        end
        2'h3: begin
          rd_addr <= rd_addr + 11'h001;
        end
      endcase
    end
  end

  // Page buffer fill, untouched by frames refused while busy
  always_ff @(posedge SCK_I) begin
    if (byte_end && is_write && !blocked) begin
      if (phase == 2'h2) begin
        ptr <= byte_in[PAGE_W-1:0];
        mask <= '0;
      end else if (phase == 2'h3) begin
        page_buf[ptr] <= byte_in;
        mask[ptr] <= 1'b1;
        ptr <= ptr + 5'h01;
      end
    end
  end

  // Byte to present at the next falling edge
  always_comb begin
    out_valid = 1'b0;
    out_byte = 8'h00;
    if (in_frame && bit_cnt == 3'h0 && phase != 2'h0) begin
      if (opcode == OP_RD_STATUS) begin
        out_valid = 1'b1;
        out_byte = stat_s2[7:0];
      end else if (phase == 2'h3 && !blocked) begin
        if (opcode == OP_RD_ARRAY) begin
          out_valid = 1'b1;
          out_byte = mem[rd_addr];
        end else if (opcode == OP_RD_SECTOR) begin
          out_valid = 1'b1;
          if (addr[ADDR_UID_BIT]) begin
            out_byte = UID_VALUE[(UID_BYTES - 1 - int'(rd_addr[3:0])) * 8 +: 8];
          end else if (addr[10:9] == SEL_DATA) begin
            out_byte = sector[rd_addr[PAGE_W-1:0]];
          end else begin
            out_byte = link_lock ? LOCK_STATUS_ON : 8'h00;
          end
        end
      end
    end
  end

  // Serial output on falling edges, MSB first
  always_ff @(negedge SCK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      tx <= 8'h00;
      SO_OE_O <= 1'b0;
    end else if (out_valid) begin
      tx <= out_byte;
      SO_OE_O <= 1'b1;
    end else begin
      tx <= {tx[6:0], 1'b0};
    end
  end

  assign SO_O = tx[7];

  // ---------------- MCLK domain logic ----------------
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
    end else begin
      cs_s1 <= CS_N_I;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      wp_s1 <= WP_N_I;
      wp_s2 <= wp_s1;
    end
  end

  // Link-side registers are quiet once select is high, so they are read here
  assign frame_end = cs_s2 && !cs_s3;
  assign cycle_in_progress = (state != SQ_IDLE);
  assign accept = frame_end && !cycle_in_progress && !blocked;
  assign aligned_cmd = (bit_cnt == 3'h0) && (phase == 2'h1);
  assign aligned_sr = (bit_cnt == 3'h0) && (phase == 2'h2);
  assign aligned_data = (bit_cnt == 3'h0) && (phase == 2'h3) && (mask != '0);
  assign cycle_done = (state == SQ_WAIT) && (tw_cnt == TW_LAST);

  always_comb begin
    unique case (bp)
      BP_NONE: prot_hit = 1'b0;
      BP_QUARTER: prot_hit = addr[10:0] >= PROT_QUARTER_BASE;
      BP_HALF: prot_hit = addr[10:0] >= PROT_HALF_BASE;
      BP_ALL: prot_hit = 1'b1;
    endcase
  end

  always_comb begin
    next_target = TGT_NONE;
    if (accept && write_enable_latch) begin
      if (opcode == OP_WR_STATUS && aligned_sr && !(status_lock_bit && !wp_s2)) begin
        next_target = TGT_STATUS;
      end else if (opcode == OP_WR_ARRAY && aligned_data && !prot_hit) begin
        next_target = TGT_ARRAY;
      end else if (opcode == OP_WR_SECTOR && aligned_data && bp != BP_ALL && !lock) begin
        if (addr[10:9] == SEL_DATA) begin
          next_target = TGT_SECTOR;
        end else if (addr[10:9] == SEL_LOCK && page_buf[addr[4:0]][LOCK_DATA_BIT]) begin
          next_target = TGT_LOCK;
        end
      end
    end
  end

  // Write sequencer: program the page, then hold busy for tW from commit
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      state <= SQ_IDLE;
      job <= '0;
      prog_idx <= '0;
      tw_cnt <= '0;
    end else begin
      unique case (state)
        SQ_IDLE: begin
          prog_idx <= '0;
          tw_cnt <= '0;
          if (next_target != TGT_NONE) begin
            job.target <= next_target;
            job.addr <= addr[10:0];
            job.mask <= mask;
            if (next_target == TGT_ARRAY || next_target == TGT_SECTOR) begin
              state <= SQ_PROGRAM;
            end else begin
              state <= SQ_WAIT;
            end
          end
        end
        SQ_PROGRAM: begin
          prog_idx <= prog_idx + 5'h01;
          tw_cnt <= tw_cnt + 1'b1;
          if (prog_idx == PAGE_LAST) begin
            state <= SQ_WAIT;
          end
        end
        SQ_WAIT: begin
          tw_cnt <= tw_cnt + 1'b1;
          if (cycle_done) begin
            state <= SQ_IDLE;
          end
        end
      endcase
    end
  end

  // Array and sector programming, only bytes that were sent
  always_ff @(posedge MCLK_I) begin
    if (state == SQ_PROGRAM && job.mask[prog_idx]) begin
      if (job.target == TGT_ARRAY) begin
        mem[{job.addr[10:5], prog_idx}] <= page_buf[prog_idx];
      end else begin
        sector[prog_idx] <= page_buf[prog_idx];
      end
    end
  end

  // Status bits
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      write_enable_latch <= 1'b0;
      bp <= BP_NONE;
      status_lock_bit <= 1'b0;
      lock <= 1'b0;
    end else begin
      if (cycle_done) begin
        write_enable_latch <= 1'b0;
      end else if (accept && aligned_cmd && opcode == OP_SET_WEL) begin
        write_enable_latch <= 1'b1;
      end else if (accept && aligned_cmd && opcode == OP_CLR_WEL) begin
        write_enable_latch <= 1'b0;
      end
      if (next_target == TGT_STATUS) begin
        status_lock_bit <= sr_data[ST_STATUS_LOCK_BIT];
        bp <= sr_data[ST_BP_HI:ST_BP_LO];
      end
      if (next_target == TGT_LOCK) begin
        lock <= 1'b1;
      end
    end
  end

  // Status word: bits 6:4 read as zero
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= {status_lock_bit, 3'b000, bp, write_enable_latch, cycle_in_progress};
    end
  end

  assign STATUS_O = status_q;
  assign LOCKED_O = lock;

endmodule : seng_spi_eeprom

//--- seng_spi_eeprom_assertions.sv
// Port-level checks for the serial EEPROM command engine
`timescale 1ns/1ps
module seng_spi_eeprom_assertions
  import seng_pkg::*;
#(
  parameter int TW_CYCLES = TW_DEFAULT_CYCLES
) (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic SCK_I,
  input wire logic CS_N_I,
  input wire logic SI_I,
  input wire logic WP_N_I,
  input wire logic SO_O,
  input wire logic SO_OE_O,
  input wire logic [7:0] STATUS_O,
  input wire logic LOCKED_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  int busy_cnt;
  // Length of the current self-timed cycle
  always_ff @(posedge MCLK_I) begin
    if (RESET_I || !STATUS_O[0]) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  property p_so_quiet; CS_N_I |-> !SO_OE_O && !SO_O; endproperty
  a_so_quiet: assert property (p_so_quiet) else $error("output active while deselected");
  property p_wip_start; $rose(STATUS_O[0]) |-> $past(CS_N_I, 3); endproperty
  a_wip_start: assert property (p_wip_start) else $error("cycle began inside a frame");
  property p_wip_len;
    $fell(STATUS_O[0]) |-> busy_cnt >= TW_CYCLES - 3 && busy_cnt <= TW_CYCLES + 3;
  endproperty
  a_wip_len: assert property (p_wip_len) else $error("cycle length wrong");
  property p_wip_max; busy_cnt <= TW_CYCLES + 3; endproperty
  a_wip_max: assert property (p_wip_max) else $error("cycle runs too long");
  property p_wel_end; $fell(STATUS_O[0]) |-> !STATUS_O[1]; endproperty
  a_wel_end: assert property (p_wel_end) else $error("latch kept after cycle");
  property p_wel_set; $rose(STATUS_O[1]) |-> CS_N_I && !STATUS_O[0]; endproperty
  a_wel_set: assert property (p_wel_set) else $error("latch set while busy");
  property p_frozen;
    STATUS_O[0] && $past(STATUS_O[0], 3) |-> $stable({STATUS_O[7:1], LOCKED_O});
  endproperty
  a_frozen: assert property (p_frozen) else $error("state moved while busy");
  property p_commit; !$stable({STATUS_O[7:2], LOCKED_O}) |-> ##[0:2] STATUS_O[0]; endproperty
  a_commit: assert property (p_commit) else $error("bits changed without cycle");
  property p_rsvd; STATUS_O[6:4] == 3'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved status bits set");
  property p_lock_keep; LOCKED_O |=> LOCKED_O; endproperty
  a_lock_keep: assert property (p_lock_keep) else $error("lock bit dropped");
  c_busy: cover property ($rose(STATUS_O[0]));
  c_lock: cover property ($rose(LOCKED_O));
  c_read: cover property (SO_OE_O && SO_O);
endmodule : seng_spi_eeprom_assertions

bind seng_spi_eeprom seng_spi_eeprom_assertions #(.TW_CYCLES(TW_CYCLES)) seng_chk_i (
  .MCLK_I(MCLK_I), .RESET_I(RESET_I), .SCK_I(SCK_I), .CS_N_I(CS_N_I), .SI_I(SI_I),
  .WP_N_I(WP_N_I), .SO_O(SO_O), .SO_OE_O(SO_OE_O), .STATUS_O(STATUS_O), .LOCKED_O(LOCKED_O));

//--- seng_host_model.sv
// Mode 0 SPI host: clock stands low outside frames
`timescale 1ns/1ps
module seng_host_model (
  input wire logic mclk_i,
  input wire logic so_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o
);
  logic [55:0] rx;
  // Select rises after time zero so the link output flops see a clearing edge
  initial begin
    sck_o = 1'b0;
    si_o = 1'b0;
    rx = '0;
    #1 cs_n_o = 1'b1;
  end
  // One frame, tx left aligned, nb bits; 12 ns link period
  task automatic xfer(input logic [55:0] tx, input int nb);
    @(negedge mclk_i);
    cs_n_o = 1'b0;
    for (int i = 0; i < nb; i++) begin
      si_o = tx[55-i];
      #6 sck_o = 1'b1;
      rx = {rx[54:0], so_i};
      #6 sck_o = 1'b0;
    end
    #2 si_o = ~si_o;
    @(negedge mclk_i);
    cs_n_o = 1'b1;
    repeat (8) @(negedge mclk_i);
  endtask : xfer
endmodule : seng_host_model

//--- seng_spi_eeprom_tb.sv
// Self-checking bench for the serial EEPROM command engine
`timescale 1ns/1ps
module seng_spi_eeprom_tb;
  import seng_pkg::*;
  localparam int TW = 80;
  // Arbitrary identifier for the bench
  localparam logic [127:0] UID = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
  logic MCLK_I = 1'b0;
  logic RESET_I, WP_N_I, SCK_I, CS_N_I, SI_I, SO_O, SO_OE_O, LOCKED_O;
  logic [7:0] STATUS_O;
  logic [55:0] rx;
  int n_fail = 0;
  int samples_checked = 0;
  always #4 MCLK_I = ~MCLK_I;
  assign rx = seng_host_model_i.rx;
  seng_spi_eeprom #(.TW_CYCLES(TW), .UID_VALUE(UID)) seng_spi_eeprom_i (.MCLK_I(MCLK_I),
    .RESET_I(RESET_I), .SCK_I(SCK_I), .CS_N_I(CS_N_I), .SI_I(SI_I), .WP_N_I(WP_N_I),
    .SO_O(SO_O), .SO_OE_O(SO_OE_O), .STATUS_O(STATUS_O), .LOCKED_O(LOCKED_O));
  // A released data line reads as the inverse of the flop, so silence cannot pass a read
  seng_host_model seng_host_model_i (.mclk_i(MCLK_I), .so_i(SO_OE_O ? SO_O : ~SO_O),
    .sck_o(SCK_I), .cs_n_o(CS_N_I), .si_o(SI_I));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic xf(input logic [55:0] tx, input int nb);
    seng_host_model_i.xfer(tx, nb);
  endtask : xf
  task automatic op(input logic [7:0] c);
    xf({c, 48'h0}, 8);
  endtask : op
  task automatic wr(input logic [55:0] tx, input int nb);
    op(OP_SET_WEL);
    xf(tx, nb);
  endtask : wr
  task automatic st(input logic [7:0] exp);
    xf({OP_RD_STATUS, 48'h0}, 24);
    chk(rx[15:0], {exp, exp});
  endtask : st
  task automatic idle;
    int n;
    n = 0;
    while (STATUS_O[0] !== 1'b0 && n < 500) begin
      @(negedge MCLK_I);
      n++;
    end
    chk(16'(n < 500), 16'h1);
  endtask : idle
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge MCLK_I);
    n_fail++;
    results;
  end
  initial begin
    RESET_I = 1'b1;
    WP_N_I = 1'b1;
    repeat (20) @(negedge MCLK_I);
    RESET_I = 1'b0;
    repeat (2) @(negedge MCLK_I);
    chk({STATUS_O, 7'h0, LOCKED_O}, 16'h0);
    st(8'h00);
    op(OP_SET_WEL);
    st(8'h02);
    op(OP_CLR_WEL);
    st(8'h00);
    wr({OP_WR_STATUS, 8'hff, 40'h0}, 15);
    st(8'h02);
    xf({OP_WR_STATUS, 8'hf3, 40'h0}, 16);
    chk({8'h00, STATUS_O}, 16'h0083);
    st(8'h83);
    idle;
    st(8'h80);
    WP_N_I = 1'b0;
    wr({OP_WR_STATUS, 8'h0c, 40'h0}, 16);
    st(8'h82);
    WP_N_I = 1'b1;
    xf({OP_WR_STATUS, 8'h00, 40'h0}, 16);
    idle;
    $display("status tests done");
    wr({OP_WR_ARRAY, 16'hf91e, 24'ha1a2a3, 8'h0}, 48);
    op(OP_SET_WEL);
    xf({OP_RD_ARRAY, 16'h011e, 32'h0}, 40);
    chk(rx[15:0], 16'hffff);
    idle;
    chk({8'h00, STATUS_O}, 16'h0000);
    xf({OP_RD_ARRAY, 16'h011e, 32'h0}, 40);
    chk(rx[15:0], 16'ha1a2);
    xf({OP_RD_ARRAY, 16'h8100, 32'h0}, 32);
    chk({8'h00, rx[7:0]}, 16'h00a3);
    wr({OP_WR_ARRAY, 16'h0600, 8'h55, 24'h0}, 32);
    idle;
    wr({OP_WR_STATUS, 8'h04, 40'h0}, 16);
    idle;
    wr({OP_WR_ARRAY, 16'h0600, 8'haa, 24'h0}, 32);
    chk({8'h00, STATUS_O}, 16'h0006);
    xf({OP_RD_ARRAY, 16'h0600, 32'h0}, 32);
    chk({8'h00, rx[7:0]}, 16'h0055);
    wr({OP_WR_STATUS, 8'h08, 40'h0}, 16);
    idle;
    wr({OP_WR_ARRAY, 16'h0400, 8'haa, 24'h0}, 32);
    chk({8'h00, STATUS_O}, 16'h000a);
    wr({OP_WR_ARRAY, 16'h03ff, 8'hc3, 24'h0}, 32);
    idle;
    xf({OP_RD_ARRAY, 16'h03ff, 32'h0}, 32);
    chk({8'h00, rx[7:0]}, 16'h00c3);
    wr({OP_WR_STATUS, 8'h0c, 40'h0}, 16);
    idle;
    wr({OP_WR_ARRAY, 16'h0000, 8'haa, 24'h0}, 32);
    chk({8'h00, STATUS_O}, 16'h000e);
    wr({OP_WR_SECTOR, 16'h0000, 8'h99, 24'h0}, 32);
    chk({8'h00, STATUS_O}, 16'h000e);
    wr({OP_WR_STATUS, 8'h00, 40'h0}, 16);
    idle;
    $display("array tests done");
    wr({OP_WR_SECTOR, 16'h001f, 16'h1122, 16'h0}, 40);
    idle;
    xf({OP_RD_SECTOR, 16'h001f, 32'h0}, 40);
    chk(rx[15:0], 16'h1122);
    wr({OP_WR_SECTOR, 16'h0400, 8'h02, 24'h0}, 32);
    idle;
    chk({15'h0000, LOCKED_O}, 16'h0001);
    xf({OP_RD_SECTOR, 16'h0400, 32'h0}, 32);
    chk({8'h00, rx[7:0]}, 16'h0002);
    wr({OP_WR_SECTOR, 16'h001f, 8'h77, 24'h0}, 32);
    xf({OP_RD_SECTOR, 16'h001f, 32'h0}, 32);
    chk({8'h00, rx[7:0]}, 16'h0011);
    xf({OP_RD_SECTOR, 16'h020f, 32'h0}, 40);
    chk(rx[15:0], {UID[7:0], UID[127:120]});
    $display("sector tests done");
    results;
  end
endmodule : seng_spi_eeprom_tb
